/* File: rtl/pba_pkg.sv */
package pba_pkg;

  // --------
  // bus commands
  // --------
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'ha;
  localparam logic [3:0] CMD_CFG_WR = 4'hb;

  // --------
  // reset values and counts
  // --------
  localparam logic [31:0] RST_BASE = 32'h0000_0000;
  localparam int MEM_DEPTH = 4;
  localparam int ABORT_CYCLES = 5;

  // --------
  // crossing word widths
  // --------
  localparam int CMD_W = 72;
  localparam int RSP_W = 35;

  // --------
  // states
  // --------
  typedef enum logic [1:0] {
    T_IDLE = 2'b00,
    T_DATA = 2'b01,
    T_TURN = 2'b10,
    T_SPEC = 2'b11
  } pba_tgt_type;

  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_ADDR = 2'b01,
    H_DATA = 2'b10,
    H_TURN = 2'b11
  } pba_ini_type;

endpackage

/* File: rtl/pba_if.sv */
`timescale 1ns/10ps
interface pba_if (
  // link clock
  input wire logic pci_clk
);
  logic rst_n;
  logic idsel;
  logic [31:0] h_ad_o, d_ad_o, ad;
  logic h_ad_oe_n, d_ad_oe_n;
  logic [3:0] h_cbe_o, cbe;
  logic h_cbe_oe_n;
  logic h_par_o, h_par_oe_n, d_par_o, d_par_oe_n, par;
  logic h_frame_o, h_frame_oe_n, frame_n;
  logic h_irdy_o, h_irdy_oe_n, irdy_n;
  logic d_devsel_o, d_devsel_oe_n, devsel_n;
  logic d_trdy_o, d_trdy_oe_n, trdy_n;
  logic d_stop_o, d_stop_oe_n, stop_n;
  logic h_perr_o, h_perr_oe_n, d_perr_o, d_perr_oe_n, perr_n;
  logic h_serr_o, h_serr_oe_n, d_serr_o, d_serr_oe_n, serr_n;
  logic d_req0_o, d_req0_oe_n, req0_n;

  // --------
  // wire levels, pulled up when undriven
  // --------
  assign ad = !d_ad_oe_n ? d_ad_o : (!h_ad_oe_n ? h_ad_o : 32'hffff_ffff);
  assign cbe = !h_cbe_oe_n ? h_cbe_o : 4'hf;
  assign par = !d_par_oe_n ? d_par_o : (!h_par_oe_n ? h_par_o : 1'b1);
  assign frame_n = h_frame_oe_n | h_frame_o;
  assign irdy_n = h_irdy_oe_n | h_irdy_o;
  assign devsel_n = d_devsel_oe_n | d_devsel_o;
  assign trdy_n = d_trdy_oe_n | d_trdy_o;
  assign stop_n = d_stop_oe_n | d_stop_o;
  assign perr_n = !d_perr_oe_n ? d_perr_o : (!h_perr_oe_n ? h_perr_o : 1'b1);
  assign serr_n = (d_serr_oe_n | d_serr_o) & (h_serr_oe_n | h_serr_o);
  assign req0_n = d_req0_oe_n | d_req0_o;

  modport device (
    input pci_clk, rst_n, idsel, ad, cbe, par, frame_n, irdy_n, req0_n,
    output d_ad_o, d_ad_oe_n, d_par_o, d_par_oe_n, d_devsel_o, d_devsel_oe_n,
    output d_trdy_o, d_trdy_oe_n, d_stop_o, d_stop_oe_n, d_perr_o, d_perr_oe_n,
    output d_serr_o, d_serr_oe_n, d_req0_o, d_req0_oe_n
  );

  modport host (
    input pci_clk, ad, par, devsel_n, trdy_n, stop_n, perr_n, serr_n, req0_n,
    input frame_n, irdy_n,
    output rst_n, idsel, h_ad_o, h_ad_oe_n, h_cbe_o, h_cbe_oe_n, h_par_o, h_par_oe_n,
    output h_frame_o, h_frame_oe_n, h_irdy_o, h_irdy_oe_n,
    output h_perr_o, h_perr_oe_n, h_serr_o, h_serr_oe_n
  );
endinterface

/* File: rtl/pba_cdc.sv */
`timescale 1ns/10ps
module pba_cdc #(
  parameter int WIDTH = 8
) (
  // source side
  input wire logic src_clk,
  input wire logic src_rst,
  input wire logic src_valid,
  input wire logic [WIDTH-1:0] src_data,
  output logic src_ready,
  // destination side
  input wire logic dst_clk,
  input wire logic dst_rst,
  output logic dst_valid,
  output logic [WIDTH-1:0] dst_data
);
  logic req, ack, ack_m, ack_s, req_m, req_s, req_d;
  logic [WIDTH-1:0] hold;

  // --------
  // source: toggle request, hold word
  // --------
  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      req <= 1'b0;
      hold <= '0;
      src_ready <= 1'b1;
    end else if (src_valid && src_ready) begin
      req <= ~req;
      hold <= src_data;
      src_ready <= 1'b0;
    end else if (ack_s == req) begin
      src_ready <= 1'b1;
    end
  end

  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      ack_m <= 1'b0;
      ack_s <= 1'b0;
    end else begin
      ack_m <= ack;
      ack_s <= ack_m;
    end
  end

  // --------
  // destination: detect toggle, capture, acknowledge
  // --------
  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      req_m <= 1'b0;
      req_s <= 1'b0;
      req_d <= 1'b0;
      ack <= 1'b0;
      dst_valid <= 1'b0;
      dst_data <= '0;
    end else begin
      req_m <= req;
      req_s <= req_m;
      req_d <= req_s;
      dst_valid <= req_s != req_d;
      if (req_s != req_d) begin
        dst_data <= hold;
        ack <= req_s;
      end
    end
  end
endmodule // pba_cdc

/* File: rtl/pba_initiator.sv */
`timescale 1ns/10ps
module pba_initiator (
  // system side
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic [31:0] cmd_addr,
  input wire logic [31:0] cmd_data,
  input wire logic [3:0] cmd_be,
  input wire logic sys_err,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [pba_pkg::RSP_W-1:0] rsp_word,
  output logic bus_serr,
  output logic bus_perr,
  output logic req_seen,
  // bus side
  pba_if.host bus
);
  import pba_pkg::*;

  logic busy, next_busy, c_rdy, c_valid, r_rdy, r_send, pend, go, fin;
  logic r1, hrst, s1, s2, rpar, rchk, rstop, rabort, rperr, rerr;
  logic [2:0] lv1, lv2, cnt;
  logic [CMD_W-1:0] c_word, cw;
  logic [31:0] rdata;
  pba_ini_type st;

  // --------
  // system side
  // --------
  assign next_busy = (cmd_valid && cmd_ready) ? 1'b1 : (rsp_valid ? 1'b0 : busy);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      cmd_ready <= 1'b0;
      lv1 <= 3'h7;
      lv2 <= 3'h7;
      {bus_serr, bus_perr, req_seen} <= 3'h0;
    end else begin
      busy <= next_busy;
      cmd_ready <= c_rdy && !next_busy;
      lv1 <= {bus.serr_n, bus.perr_n, bus.req0_n};
      lv2 <= lv1;
      {bus_serr, bus_perr, req_seen} <= ~lv2;
    end
  end

  pba_cdc #(.WIDTH(CMD_W)) u_cmd (
    .src_clk(sys_clk), .src_rst(sys_rst), .src_valid(cmd_valid && cmd_ready),
    .src_data({cmd_code, cmd_addr, cmd_data, cmd_be}), .src_ready(c_rdy),
    .dst_clk(bus.pci_clk), .dst_rst(hrst), .dst_valid(c_valid), .dst_data(c_word)
  );

  pba_cdc #(.WIDTH(RSP_W)) u_rsp (
    .src_clk(bus.pci_clk), .src_rst(hrst), .src_valid(r_send),
    .src_data({rdata, rperr, rstop, rabort}), .src_ready(r_rdy),
    .dst_clk(sys_clk), .dst_rst(sys_rst), .dst_valid(rsp_valid), .dst_data(rsp_word)
  );

  // --------
  // link reset and error request
  // --------
  always_ff @(posedge bus.pci_clk) begin
    r1 <= sys_rst;
    hrst <= r1;
    bus.rst_n <= ~hrst;
    s1 <= sys_err;
    s2 <= s1;
  end

  // --------
  // transaction sequencer
  // --------
  assign go = pend && bus.frame_n && bus.irdy_n && r_rdy;
  assign fin = st == H_DATA && (!bus.trdy_n || !bus.stop_n ||
               (bus.devsel_n && cnt == 3'(ABORT_CYCLES - 1)));

  always_ff @(posedge bus.pci_clk) begin
    if (hrst) begin
      pend <= 1'b0;
      cw <= '0;
    end else if (c_valid) begin
      pend <= 1'b1;
      cw <= c_word;
    end else if (st == H_IDLE && go) begin
      pend <= 1'b0;
    end
  end

  always_ff @(posedge bus.pci_clk) begin
    if (hrst) begin
      st <= H_IDLE;
      bus.h_frame_o <= 1'b1;
      bus.h_frame_oe_n <= 1'b1;
      bus.h_irdy_o <= 1'b1;
      bus.h_irdy_oe_n <= 1'b1;
      bus.h_ad_o <= 32'h0;
      bus.h_ad_oe_n <= 1'b1;
      bus.h_cbe_o <= 4'h0;
      bus.h_cbe_oe_n <= 1'b1;
      bus.idsel <= 1'b0;
      cnt <= 3'h0;
    end else begin
      case (st)
        H_IDLE: begin
          if (go) begin
            st <= H_ADDR;
            bus.h_frame_o <= 1'b0;
            bus.h_frame_oe_n <= 1'b0;
            bus.h_irdy_o <= 1'b1;
            bus.h_irdy_oe_n <= 1'b0;
            bus.h_ad_o <= cw[67:36];
            bus.h_ad_oe_n <= 1'b0;
            bus.h_cbe_o <= cw[71:68];
            bus.h_cbe_oe_n <= 1'b0;
            bus.idsel <= cw[71:69] == CMD_CFG_RD[3:1];
          end
        end
        H_ADDR: begin
          st <= H_DATA;
          bus.h_frame_o <= 1'b1;
          bus.h_irdy_o <= 1'b0;
          bus.h_cbe_o <= cw[3:0];
          bus.h_ad_o <= cw[35:4];
          bus.h_ad_oe_n <= ~cw[68];
          bus.idsel <= 1'b0;
          cnt <= 3'h0;
        end
        H_DATA: begin
          if (fin) begin
            st <= H_TURN;
            bus.h_irdy_o <= 1'b1;
            bus.h_frame_oe_n <= 1'b1;
            bus.h_ad_oe_n <= 1'b1;
            bus.h_cbe_oe_n <= 1'b1;
          end else begin
            cnt <= cnt + 3'h1;
          end
        end
        H_TURN: begin
          st <= H_IDLE;
          bus.h_irdy_oe_n <= 1'b1;
        end
        default: st <= H_IDLE;
      endcase
    end
  end

  // --------
  // read capture, parity and response
  // --------
  assign rerr = st == H_TURN && rchk && (bus.par != rpar);

  always_ff @(posedge bus.pci_clk) begin
    if (hrst) begin
      rdata <= 32'h0;
      rpar <= 1'b0;
      rchk <= 1'b0;
      rstop <= 1'b0;
      rabort <= 1'b0;
      rperr <= 1'b0;
      r_send <= 1'b0;
    end else begin
      r_send <= st == H_TURN;
      if (fin) begin
        rdata <= bus.ad;
        rpar <= ^bus.ad;
        rchk <= !cw[68] && !bus.trdy_n;
        rstop <= !bus.stop_n;
        rabort <= bus.trdy_n && bus.stop_n;
      end
      if (st == H_TURN) begin
        rperr <= rerr;
      end
    end
  end

  always_ff @(posedge bus.pci_clk) begin
    if (hrst) begin
      bus.h_par_o <= 1'b0;
      bus.h_par_oe_n <= 1'b1;
      bus.h_perr_o <= 1'b1;
      bus.h_perr_oe_n <= 1'b1;
      bus.h_serr_o <= 1'b0;
      bus.h_serr_oe_n <= 1'b1;
    end else begin
      bus.h_par_o <= ^bus.h_ad_o;
      bus.h_par_oe_n <= bus.h_ad_oe_n;
      bus.h_perr_o <= ~rerr;
      bus.h_perr_oe_n <= ~(rerr || !bus.h_perr_o);
      bus.h_serr_o <= 1'b0;
      bus.h_serr_oe_n <= ~s2;
    end
  end
endmodule // pba_initiator

/* File: rtl/pba_target.sv */
`timescale 1ns/10ps
// Summary of operation
// - address first, then write or read data
// - command in address, low byte enables after
// - even parity on address/data, driver follows owner
// - frame starts transfer, release marks last phase
// - target ready low completes data phase
// - initiator ready low completes data phase
// - stop low ends the current transaction
// - parity error low two clocks after data
// - system error on address or special-cycle parity
// - all bus signals on rising link clock
// - init select driven by initiator in config address phase
// - link reset low clears bus logic except the storage lanes, which keep their data
// - request zero driven only in add-in mode
module pba_target #(
  parameter int DEPTH = pba_pkg::MEM_DEPTH,
  parameter logic [31:0] BASE_RST = pba_pkg::RST_BASE,
  localparam int IW = $clog2(DEPTH)
) (
  // system side
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic mode_host,
  input wire logic user_req,
  output logic wr_valid,
  output logic [IW+31:0] wr_word,
  output logic ext_req,
  // bus side
  pba_if.device bus
);
  import pba_pkg::*;

  logic rs1, rs2, prst;
  logic hm1, hm, ur1, ur, e1, e2;
  logic fq, rd, cfg, start, mhit, chit, hit, acc, take, done, w_rdy;
  logic achk, apar, dchk, dspec, dpar, aerr, derr;
  logic [IW-1:0] idx;
  logic [31:0] base, rdata_m, rdata;
  pba_tgt_type st;

  // --------
  // link reset and strap crossings
  // --------
  always_ff @(posedge bus.pci_clk) begin
    rs1 <= bus.rst_n;
    rs2 <= rs1;
  end

  assign prst = ~rs2;

  always_ff @(posedge bus.pci_clk) begin
    hm1 <= mode_host;
    hm <= hm1;
    ur1 <= user_req;
    ur <= ur1;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      e1 <= 1'b1;
      e2 <= 1'b1;
      ext_req <= 1'b0;
    end else begin
      e1 <= bus.req0_n;
      e2 <= e1;
      ext_req <= mode_host && !e2;
    end
  end

  // --------
  // address decode
  // --------
  assign start = st == T_IDLE && !bus.frame_n && fq;
  assign mhit = (bus.cbe == CMD_MEM_RD || bus.cbe == CMD_MEM_WR) &&
                bus.ad[31:IW+2] == base[31:IW+2];
  assign chit = (bus.cbe == CMD_CFG_RD || bus.cbe == CMD_CFG_WR) &&
                bus.idsel && !hm;
  assign hit = mhit || chit;
  assign acc = !bus.cbe[0] || chit || w_rdy;
  assign take = st == T_DATA && !bus.irdy_n && !bus.d_trdy_o;
  assign done = st == T_DATA && bus.frame_n && !bus.irdy_n &&
                (!bus.d_trdy_o || !bus.d_stop_o);

  always_ff @(posedge bus.pci_clk) begin
    if (prst) begin
      fq <= 1'b1;
      rd <= 1'b0;
      cfg <= 1'b0;
      idx <= '0;
    end else begin
      fq <= bus.frame_n;
      if (start) begin
        rd <= !bus.cbe[0];
        cfg <= chit;
        idx <= bus.ad[IW+1:2];
      end
    end
  end

  // --------
  // storage
  // --------
  for (genvar b = 0; b < 4; b++) begin : g_lane
    logic [7:0] lane [DEPTH];

    always_ff @(posedge bus.pci_clk) begin
      if (take && !rd && !cfg && !bus.cbe[b]) begin
        lane[idx] <= bus.ad[8*b +: 8];
      end
    end

    assign rdata_m[8*b +: 8] = lane[idx];
  end

  assign rdata = cfg ? base : rdata_m;

  always_ff @(posedge bus.pci_clk) begin
    if (prst) begin
      base <= BASE_RST;
    end else if (take && !rd && cfg) begin
      base <= bus.ad;
    end
  end

  // --------
  // target handshake
  // --------
  always_ff @(posedge bus.pci_clk) begin
    if (prst) begin
      st <= T_IDLE;
      bus.d_devsel_o <= 1'b1;
      bus.d_devsel_oe_n <= 1'b1;
      bus.d_trdy_o <= 1'b1;
      bus.d_trdy_oe_n <= 1'b1;
      bus.d_stop_o <= 1'b1;
      bus.d_stop_oe_n <= 1'b1;
      bus.d_ad_o <= 32'h0;
      bus.d_ad_oe_n <= 1'b1;
    end else begin
      case (st)
        T_IDLE: begin
          if (start && hit) begin
            st <= T_DATA;
            bus.d_devsel_o <= 1'b0;
            bus.d_devsel_oe_n <= 1'b0;
            bus.d_trdy_oe_n <= 1'b0;
            bus.d_stop_oe_n <= 1'b0;
            bus.d_trdy_o <= !bus.cbe[0] || !acc;
            bus.d_stop_o <= acc;
          end else if (start && bus.cbe == CMD_SPECIAL) begin
            st <= T_SPEC;
          end
        end
        T_DATA: begin
          if (done) begin
            st <= T_TURN;
            bus.d_devsel_o <= 1'b1;
            bus.d_trdy_o <= 1'b1;
            bus.d_stop_o <= 1'b1;
            bus.d_ad_oe_n <= 1'b1;
          end else if (take) begin
            bus.d_trdy_o <= 1'b1;
            bus.d_stop_o <= 1'b0;
          end else if (rd && bus.d_ad_oe_n) begin
            bus.d_ad_o <= rdata;
            bus.d_ad_oe_n <= 1'b0;
            bus.d_trdy_o <= 1'b0;
          end
        end
        T_TURN: begin
          st <= T_IDLE;
          bus.d_devsel_oe_n <= 1'b1;
          bus.d_trdy_oe_n <= 1'b1;
          bus.d_stop_oe_n <= 1'b1;
        end
        T_SPEC: begin
          if (!bus.irdy_n) begin
            st <= T_IDLE;
          end
        end
        default: st <= T_IDLE;
      endcase
    end
  end

  // --------
  // parity generation and checking
  // --------
  assign aerr = achk && (bus.par != apar);
  assign derr = dchk && (bus.par != dpar);

  always_ff @(posedge bus.pci_clk) begin
    if (prst) begin
      achk <= 1'b0;
      apar <= 1'b0;
      dchk <= 1'b0;
      dspec <= 1'b0;
      dpar <= 1'b0;
    end else begin
      achk <= start;
      apar <= ^bus.ad;
      dchk <= (take && !rd) || (st == T_SPEC && !bus.irdy_n);
      dspec <= st == T_SPEC;
      dpar <= ^bus.ad;
    end
  end

  always_ff @(posedge bus.pci_clk) begin
    if (prst) begin
      bus.d_par_o <= 1'b0;
      bus.d_par_oe_n <= 1'b1;
      bus.d_perr_o <= 1'b1;
      bus.d_perr_oe_n <= 1'b1;
      bus.d_serr_o <= 1'b0;
      bus.d_serr_oe_n <= 1'b1;
    end else begin
      bus.d_par_o <= ^bus.d_ad_o;
      bus.d_par_oe_n <= bus.d_ad_oe_n;
      bus.d_perr_o <= ~(derr && !dspec);
      bus.d_perr_oe_n <= ~((derr && !dspec) || !bus.d_perr_o);
      bus.d_serr_o <= 1'b0;
      bus.d_serr_oe_n <= ~(aerr || (derr && dspec));
    end
  end

  // --------
  // request zero pin
  // --------
  always_ff @(posedge bus.pci_clk) begin
    if (prst) begin
      bus.d_req0_o <= 1'b1;
      bus.d_req0_oe_n <= 1'b1;
    end else begin
      bus.d_req0_o <= ~ur;
      bus.d_req0_oe_n <= hm;
    end
  end

  // --------
  // write events to system side
  // --------
  pba_cdc #(.WIDTH(IW + 32)) u_wr (
    .src_clk(bus.pci_clk),
    .src_rst(prst),
    .src_valid(take && !rd && !cfg),
    .src_data({idx, bus.ad}),
    .src_ready(w_rdy),
    .dst_clk(sys_clk),
    .dst_rst(sys_rst),
    .dst_valid(wr_valid),
    .dst_data(wr_word)
  );
endmodule // pba_target

/* File: testbench/pba_properties.sv */
`timescale 1ns/10ps
module pba_properties
  import pba_pkg::*;
(
  // link side
  input wire logic pci_clk,
  input wire logic rst_n,
  input wire logic idsel,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe,
  input wire logic par,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic stop_n,
  input wire logic devsel_n,
  input wire logic perr_n,
  // drive enables
  input wire logic h_ad_oe_n,
  input wire logic d_ad_oe_n,
  input wire logic h_cbe_oe_n,
  input wire logic d_trdy_oe_n,
  input wire logic d_devsel_oe_n
);
  // ----------------
  // link properties
  // ----------------
  default clocking cb @(posedge pci_clk);
  endclocking

  sequence s_addr;
    $fell(frame_n);
  endsequence
  sequence s_taken;
    !irdy_n && !trdy_n;
  endsequence
  sequence s_par_ok;
    par == ^$past(ad);
  endsequence

  property p_par;
    disable iff (!rst_n) (!h_ad_oe_n || !d_ad_oe_n) |=> s_par_ok;
  endproperty
  property p_perr;
    disable iff (!rst_n) s_taken ##1 s_par_ok |=> perr_n;
  endproperty
  property p_single;
    disable iff (!rst_n) s_addr |=> frame_n && !irdy_n;
  endproperty
  property p_cbe;
    disable iff (!rst_n) s_addr |-> !h_cbe_oe_n && irdy_n ##1 !h_cbe_oe_n;
  endproperty
  property p_wr;
    disable iff (!rst_n) s_addr and cbe[0] |=> !h_ad_oe_n && d_ad_oe_n;
  endproperty
  property p_rd;
    disable iff (!rst_n) s_addr and !cbe[0] |=> h_ad_oe_n && trdy_n;
  endproperty
  property p_trdy;
    disable iff (!rst_n) !trdy_n || !stop_n |-> !devsel_n;
  endproperty
  property p_exit;
    disable iff (!rst_n) (s_taken and frame_n) |=> (trdy_n && !d_trdy_oe_n) ##1 d_trdy_oe_n;
  endproperty
  property p_end;
    disable iff (!rst_n) s_addr |-> ##[2:10] irdy_n;
  endproperty
  property p_idsel;
    disable iff (!rst_n) idsel |-> $fell(frame_n) && (cbe == CMD_CFG_RD || cbe == CMD_CFG_WR);
  endproperty
  property p_rst;
    (!rst_n)[*4] |-> d_ad_oe_n && d_trdy_oe_n && d_devsel_oe_n;
  endproperty

  a_par: assert property (p_par) else $error("parity does not follow ad");
  a_perr: assert property (p_perr) else $error("parity error on good data");
  a_single: assert property (p_single) else $error("frame not ended at data");
  a_cbe: assert property (p_cbe) else $error("cbe not driven");
  a_wr: assert property (p_wr) else $error("write data owner wrong");
  a_rd: assert property (p_rd) else $error("read turnaround wrong");
  a_trdy: assert property (p_trdy) else $error("ready or stop without select");
  a_exit: assert property (p_exit) else $error("target ready not released");
  a_end: assert property (p_end) else $error("data phase not ended");
  a_idsel: assert property (p_idsel) else $error("idsel outside config");
  a_rst: assert property (p_rst) else $error("device drives in reset");
endmodule // pba_properties

/* File: testbench/test_pci_bus_agent_signalling.sv */
`timescale 1ns/10ps
module test_pci_bus_agent_signalling;
  import pba_pkg::*;
  localparam logic [34:0] ALL = '1;
  localparam logic [34:0] FLG = 35'h7;
  logic sys_clk, sys_rst, pci_clk, cmd_valid, sys_err, mode_host, user_req;
  logic [3:0] cmd_code, cmd_be;
  logic [31:0] cmd_addr, cmd_data;
  logic cmd_ready, rsp_valid, bus_serr, bus_perr, req_seen, wr_valid, ext_req;
  logic [RSP_W-1:0] rsp_word;
  logic [33:0] wr_word, wr_seen;
  int n_errors = 0;
  int n_checks = 0;
  int wr_cnt = 0;
  int cyc = 0;

  // ----------------
  // ends and checker
  // ----------------
  pba_if bus (.pci_clk(pci_clk));
  pba_initiator u_pba_initiator (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_be(cmd_be),
    .sys_err(sys_err), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_word(rsp_word),
    .bus_serr(bus_serr), .bus_perr(bus_perr), .req_seen(req_seen), .bus(bus));
  pba_target u_pba_target (.sys_clk(sys_clk), .sys_rst(sys_rst), .mode_host(mode_host),
    .user_req(user_req), .wr_valid(wr_valid), .wr_word(wr_word), .ext_req(ext_req), .bus(bus));
  pba_properties u_pba_properties (.pci_clk(pci_clk), .rst_n(bus.rst_n), .idsel(bus.idsel),
    .ad(bus.ad), .cbe(bus.cbe), .par(bus.par), .frame_n(bus.frame_n), .irdy_n(bus.irdy_n),
    .trdy_n(bus.trdy_n), .stop_n(bus.stop_n), .devsel_n(bus.devsel_n), .perr_n(bus.perr_n),
    .h_ad_oe_n(bus.h_ad_oe_n), .d_ad_oe_n(bus.d_ad_oe_n), .h_cbe_oe_n(bus.h_cbe_oe_n),
    .d_trdy_oe_n(bus.d_trdy_oe_n), .d_devsel_oe_n(bus.d_devsel_oe_n));

  // ----------------
  // clocks, events, timeout
  // ----------------
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    pci_clk = 1'b0;
    #1.7;
    forever #3 pci_clk = ~pci_clk;
  end
  always @(negedge sys_clk) begin
    cyc <= cyc + 1;
    if (wr_valid === 1'b1) begin
      wr_seen <= wr_word;
      wr_cnt <= wr_cnt + 1;
    end
    if (cyc == 6000) begin
      n_errors++;
      give_verdict();
    end
  end

  // ----------------
  // tasks
  // ----------------
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk_word(input string name, input logic [34:0] exp, input logic [34:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk_word(name, {34'h0, exp}, {34'h0, got});
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic do_reset();
    sys_rst = 1'b1;
    wait_cyc(10);
    sys_rst = 1'b0;
    wait_cyc(10);
  endtask
  task automatic xfer(input logic [3:0] c, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] b, input logic [34:0] exp, input logic [34:0] m);
    int k;
    int w0;
    k = 0;
    w0 = wr_cnt;
    while (cmd_ready !== 1'b1 && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    cmd_code = c;
    cmd_addr = a;
    cmd_data = d;
    cmd_be = b;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    chk_bit("rsp_valid", 1'b1, rsp_valid);
    chk_word("rsp_word", exp & m, rsp_word & m);
    wait_cyc(12);
    if (c == CMD_MEM_WR && exp[0] == 1'b0) begin
      chk_word("wr_count", 35'(w0 + 1), 35'(wr_cnt));
      chk_word("wr_word", {1'b0, a[3:2], d}, {1'b0, wr_seen});
    end
  endtask

  // ----------------
  // sequence of tests
  // ----------------
  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_code = 4'h0;
    cmd_addr = 32'h0;
    cmd_data = 32'h0;
    cmd_be = 4'h0;
    sys_err = 1'b0;
    mode_host = 1'b0;
    user_req = 1'b0;
    do_reset();
    for (int i = 0; i < 4; i++) begin
      xfer(CMD_MEM_WR, 32'(i * 4), 32'hc3a5_0000 + 32'(i), 4'h0, 35'h0, FLG);
    end
    for (int i = 0; i < 4; i++) begin
      xfer(CMD_MEM_RD, 32'(i * 4), 32'h0, 4'h0, {32'hc3a5_0000 + 32'(i), 3'h0}, ALL);
    end
    xfer(CMD_MEM_WR, 32'h4, 32'h0000_9988, 4'hc, 35'h0, FLG);
    xfer(CMD_MEM_RD, 32'h4, 32'h0, 4'h0, {32'hc3a5_9988, 3'h0}, ALL);
    xfer(CMD_MEM_RD, 32'h100, 32'h0, 4'h0, 35'h1, FLG);
    xfer(CMD_CFG_WR, 32'h0, 32'h0000_1000, 4'h0, 35'h0, FLG);
    xfer(CMD_CFG_RD, 32'h0, 32'h0, 4'h0, {32'h0000_1000, 3'h0}, ALL);
    xfer(CMD_MEM_RD, 32'h1004, 32'h0, 4'h0, {32'hc3a5_9988, 3'h0}, ALL);
    xfer(CMD_MEM_RD, 32'h4, 32'h0, 4'h0, 35'h1, FLG);
    xfer(CMD_MEM_WR, 32'h100c, 32'h5a5a_0f0f, 4'h0, 35'h0, FLG);
    xfer(CMD_SPECIAL, 32'h0, 32'h1234_5678, 4'h0, 35'h1, FLG);
    mode_host = 1'b1;
    user_req = 1'b1;
    wait_cyc(20);
    chk_bit("req_seen", 1'b0, req_seen);
    chk_bit("ext_req", 1'b0, ext_req);
    xfer(CMD_CFG_RD, 32'h0, 32'h0, 4'h0, 35'h1, FLG);
    mode_host = 1'b0;
    wait_cyc(20);
    chk_bit("req_seen", 1'b1, req_seen);
    chk_bit("ext_req", 1'b0, ext_req);
    user_req = 1'b0;
    sys_err = 1'b1;
    wait_cyc(20);
    chk_bit("bus_serr", 1'b1, bus_serr);
    sys_err = 1'b0;
    wait_cyc(20);
    chk_bit("bus_serr", 1'b0, bus_serr);
    chk_bit("bus_perr", 1'b0, bus_perr);
    do_reset();
    xfer(CMD_CFG_RD, 32'h0, 32'h0, 4'h0, {RST_BASE, 3'h0}, ALL);
    give_verdict();
  end
endmodule // test_pci_bus_agent_signalling
